// ===== core/psp_pkg.sv
// psp_pkg: register map, field positions, reset values and timing constants
package psp_pkg;
   // =========================================================
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_DATA = 8'h08;
   localparam logic [7:0] IDX_PINS = 8'h09;
   localparam logic [7:0] IDX_INTC = 8'h0B;
   localparam logic [7:0] IDX_FLAG = 8'h0C;
   localparam logic [7:0] IDX_STAT = 8'h89;
   localparam logic [7:0] IDX_MASK = 8'h8C;
   localparam logic [7:0] IDX_ANLG = 8'h9F;
   localparam logic [7:0] IDX_DDIR = 8'h88;
   localparam int ADDR_W = 10;
   localparam int AIDX_LSB = 2;
   // =========================================================
   // status/direction register fields
   localparam int ST_IN_FULL = 7;
   localparam int ST_OUT_FULL = 6;
   localparam int ST_OVR = 5;
   localparam int ST_MODE = 4;
   localparam int FLAG_PSP = 7;
   localparam int NSTROBE = 3;
   localparam int SB_RD = 0;
   localparam int SB_WR = 1;
   localparam int SB_CS = 2;
   localparam logic [7:0] STAT_WMASK = 8'h37;
   localparam logic [2:0] DIR_RESET = 3'h7;
   localparam logic [7:0] DDIR_RESET = 8'hFF;
   localparam logic [2:0] ANLG_MASK = 3'h7;
   // =========================================================
   // phase sequencer: four internal phases per device cycle
   localparam logic [1:0] PH_TWO = 2'h1;
   localparam logic [1:0] PH_FOUR = 2'h3;
   // =========================================================
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =========================================================
   // completion tracker states, gray along the path
   typedef enum logic [1:0] {
      PSP_IDLE = 2'b00,
      PSP_BUSY = 2'b01,
      PSP_WAIT_Q2 = 2'b11,
      PSP_WAIT_Q4 = 2'b10
   } psp_cyc_t;
endpackage : psp_pkg

// ===== core/psp_sync.sv
// psp_sync: two-flop synchroniser for the three strobe pins
`timescale 1ns/1ps
module psp_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] pin_n,
   psp_sync_if.src sif
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] stable;
   } psp_sync_st_t;
   psp_sync_st_t r;
   psp_sync_st_t next_r;
   // =========================================================
   // first stage feeds the second only
   always_comb begin
      next_r.meta = pin_n;
      next_r.stable = r.meta;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '{meta: 3'h7, stable: 3'h7};
      end else begin
         r <= next_r;
      end
   end
   assign sif.level_n = r.stable;
endmodule : psp_sync

// ===== core/psp_sync_if.sv
// psp_sync_if: synchronised strobe levels passed to the main module
`timescale 1ns/1ps
interface psp_sync_if;
   logic [2:0] level_n;
   modport src (output level_n);
   modport dst (input level_n);
endinterface : psp_sync_if

// ===== core/psp_top.sv
// psp_top: parallel slave port with axi4-lite register access
`timescale 1ns/1ps
//
// Overview of operation
// RULE1: slave-mode select bit turns the 8-bit data port into a slave port
// RULE2: strobe pins 0,1,2 are read, write and chip select, all active low
// RULE3: master drives select low to select; strobes ignored when unselected
// RULE4: firmware sets strobe pins to input and digital before slave mode
// RULE5: one address: write loads outbound latch, read returns inbound latch
// RULE6: in slave mode strobes alone steer data pins, direction reg ignored
// RULE7: write end sets input-full at phase four after next phase two
// RULE8: interrupt flag set in same phase-four cycle as input-full
// RULE9: in slave mode only a firmware read of the inbound latch clears input-full
// RULE10: second write before firmware read sets input-overrun flag
// RULE11: read start clears output-full and drives outbound latch on pins
// RULE12: read end sets interrupt flag at phase four after next phase two
// RULE13: output-full stays clear until firmware writes the outbound latch
// RULE14: slave mode off holds both full flags clear, overrun kept
// RULE15: overrun flag cleared only by firmware writing zero
// RULE16: interrupt flag sticky until cleared; request only when masked in
// RULE17: strobe direction bit one is input, zero output; reset to ones
// RULE18: strobes pass through synchronisers before level detection
// RULE19: full flags and bit 3 ignore writes; reserved bits read zero
module psp_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] data_pin_i,
   output logic [7:0] data_pin_o,
   output logic [7:0] data_pin_oe,
   input wire logic [2:0] strobe_pin_i,
   output logic [2:0] strobe_pin_o,
   output logic [2:0] strobe_pin_oe,
   output logic irq
);
   typedef struct packed {
      logic awr;
      logic wr;
      logic [7:0] aw_idx;
      logic [7:0] wdata;
      logic wen;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] out_latch;
      logic [7:0] in_latch;
      logic [7:0] pin_latch;
      logic [7:0] pin_dly;
      logic [2:0] strobe_latch;
      logic [7:0] data_pin_dir;
      logic [2:0] strobe_pin_dir;
      logic slave_mode_sel;
      logic in_full_flag;
      logic out_full_flag;
      logic in_overrun_flag;
      logic [7:0] flag_reg;
      logic [7:0] mask_reg;
      logic [7:0] intc_reg;
      logic [2:0] analog_sel_field;
      logic [1:0] phase;
      psp_pkg::psp_cyc_t cyc;
      logic cyc_is_wr;
      logic [7:0] dout;
      logic [7:0] doe;
      logic [2:0] sout;
      logic [2:0] soe;
      logic irq;
      logic awready;
      logic wready;
   } psp_st_t;

   psp_st_t r;
   psp_st_t next_r;
   psp_sync_if sif ();

   // =========================================================
   // strobe synchronisers
   psp_sync u_sync ( // [RULE18]
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_n(strobe_pin_i),
      .sif(sif)
   );

   function automatic logic addr_hit(input logic [7:0] idx);
      unique case (idx)
         psp_pkg::IDX_DATA, psp_pkg::IDX_PINS, psp_pkg::IDX_INTC,
         psp_pkg::IDX_FLAG, psp_pkg::IDX_STAT, psp_pkg::IDX_MASK,
         psp_pkg::IDX_ANLG, psp_pkg::IDX_DDIR: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction : addr_hit

   // firmware read of the inbound latch, decoded in two places
   function automatic logic data_read(input logic rd,
      input logic [7:0] idx);
      data_read = rd && (idx == psp_pkg::IDX_DATA);
   endfunction : data_read

   // =========================================================
   // strobe decode and read mux
   logic sel;
   logic rd_act;
   logic wr_act;
   logic cyc_end;
   logic set_fire;
   logic do_wr;
   logic do_rd;
   logic [7:0] ar_idx;
   logic [7:0] rd_val;

   always_comb begin
      sel = r.slave_mode_sel && !sif.level_n[psp_pkg::SB_CS]; // [RULE3]
      rd_act = sel && !sif.level_n[psp_pkg::SB_RD]; // [RULE2]
      wr_act = sel && !sif.level_n[psp_pkg::SB_WR]; // [RULE2]
      ar_idx = s_axi_araddr[psp_pkg::AIDX_LSB +: 8];
      do_wr = r.awr && r.wr && !r.bvalid;
      do_rd = s_axi_arvalid && r.arready;
      rd_val = 8'h00;
      unique case (ar_idx)
         psp_pkg::IDX_DATA: rd_val = r.in_latch; // [RULE5]
         psp_pkg::IDX_PINS: rd_val = {5'h00, r.strobe_latch};
         psp_pkg::IDX_INTC: rd_val = r.intc_reg;
         psp_pkg::IDX_FLAG: rd_val = r.flag_reg;
         psp_pkg::IDX_STAT: rd_val = {r.in_full_flag, r.out_full_flag,
            r.in_overrun_flag, r.slave_mode_sel, 1'b0,
            r.strobe_pin_dir}; // [RULE19]
         psp_pkg::IDX_MASK: rd_val = r.mask_reg;
         psp_pkg::IDX_DDIR: rd_val = r.data_pin_dir;
         psp_pkg::IDX_ANLG: rd_val = {5'h00, r.analog_sel_field};
         default: rd_val = 8'h00;
      endcase
   end

   // =========================================================
   // main next-state logic
   always_comb begin
      next_r = r;
      cyc_end = 1'b0;
      set_fire = 1'b0;
      next_r.phase = r.phase + 2'h1;
      next_r.pin_latch = data_pin_i;
      next_r.pin_dly = r.pin_latch;
      next_r.strobe_latch = strobe_pin_i;

      // ======================================================
      // axi write channel
      if (s_axi_awvalid && !r.awr) begin
         next_r.awr = 1'b1;
         next_r.awready = 1'b0;
         next_r.aw_idx = s_axi_awaddr[psp_pkg::AIDX_LSB +: 8];
      end
      if (s_axi_wvalid && !r.wr) begin
         next_r.wr = 1'b1;
         next_r.wready = 1'b0;
         next_r.wdata = s_axi_wdata[7:0];
         next_r.wen = s_axi_wstrb[0];
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
         next_r.awr = 1'b0;
         next_r.wr = 1'b0;
         next_r.awready = 1'b1;
         next_r.wready = 1'b1;
      end
      if (do_wr) begin
         next_r.bvalid = 1'b1;
         next_r.bresp = addr_hit(r.aw_idx) ? psp_pkg::RESP_OKAY :
            psp_pkg::RESP_SLVERR;
      end

      // ======================================================
      // axi read channel
      if (do_rd) begin
         next_r.arready = 1'b0;
         next_r.rvalid = 1'b1;
         next_r.rdata = {24'h000000, rd_val};
         next_r.rresp = addr_hit(ar_idx) ? psp_pkg::RESP_OKAY :
            psp_pkg::RESP_SLVERR;
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
         next_r.arready = 1'b1;
      end
      if (data_read(do_rd, ar_idx)) begin
         next_r.in_full_flag = 1'b0; // [RULE9]
      end

      // ======================================================
      // register writes (byte lane 0 carries the data)
      if (do_wr && r.wen) begin
         unique case (r.aw_idx)
            psp_pkg::IDX_DATA: begin
               next_r.out_latch = r.wdata; // [RULE5]
               if (r.slave_mode_sel) next_r.out_full_flag = 1'b1; // [RULE13]
            end
            psp_pkg::IDX_PINS: begin
               // port pins read back live; nothing to store
               next_r.strobe_latch = strobe_pin_i;
            end
            psp_pkg::IDX_INTC: begin
               next_r.intc_reg = r.wdata;
            end
            psp_pkg::IDX_FLAG: begin
               // write one clears the sticky flag bits
               next_r.flag_reg = r.flag_reg & ~r.wdata; // [RULE16]
            end
            psp_pkg::IDX_STAT: begin
               next_r.slave_mode_sel = r.wdata[psp_pkg::ST_MODE]; // [RULE1]
               next_r.strobe_pin_dir = r.wdata[2:0]; // [RULE17]
               if (!r.wdata[psp_pkg::ST_OVR])
                  next_r.in_overrun_flag = 1'b0; // [RULE15]
            end
            psp_pkg::IDX_DDIR: begin
               // stored but ignored by the pins while slave mode is on
               next_r.data_pin_dir = r.wdata; // [RULE6]
            end
            psp_pkg::IDX_MASK: begin
               next_r.mask_reg = r.wdata;
            end
            psp_pkg::IDX_ANLG: begin
               next_r.analog_sel_field = r.wdata[2:0] & psp_pkg::ANLG_MASK;
            end
            default: next_r.intc_reg = r.intc_reg;
         endcase
      end

      // ======================================================
      // external cycle tracking
      unique case (r.cyc)
         psp_pkg::PSP_IDLE: begin
            if (wr_act || rd_act) begin
               next_r.cyc = psp_pkg::PSP_BUSY;
               next_r.cyc_is_wr = wr_act;
               if (!wr_act) next_r.out_full_flag = 1'b0; // [RULE11]
            end
         end
         psp_pkg::PSP_BUSY: begin
            // data delayed to match the strobe sync, so the
            // bus value after release never lands in the latch
            if (r.cyc_is_wr && wr_act) next_r.in_latch = r.pin_dly;
            cyc_end = r.cyc_is_wr ? !wr_act : !rd_act; // [RULE7] [RULE12]
            if (cyc_end) next_r.cyc = psp_pkg::PSP_WAIT_Q2;
         end
         psp_pkg::PSP_WAIT_Q2: begin
            if (r.phase == psp_pkg::PH_TWO)
               next_r.cyc = psp_pkg::PSP_WAIT_Q4; // [RULE7]
         end
         psp_pkg::PSP_WAIT_Q4: begin
            if (r.phase == psp_pkg::PH_FOUR) begin
               set_fire = 1'b1;
               next_r.cyc = psp_pkg::PSP_IDLE;
            end
         end
      endcase

      // ======================================================
      // completion flags
      if (set_fire) begin
         if (r.cyc_is_wr) begin
            // ordering: overrun judged against flag before this write
            if (r.in_full_flag && !data_read(do_rd, ar_idx))
               next_r.in_overrun_flag = 1'b1; // [RULE10]
            next_r.in_full_flag = 1'b1; // [RULE7]
         end
         next_r.flag_reg[psp_pkg::FLAG_PSP] = 1'b1; // [RULE8] [RULE12]
      end

      // ======================================================
      // slave mode off
      // a cycle cut by leaving slave mode is dropped; one at phase four in the first cycle off still sets the interrupt flag
      if (!r.slave_mode_sel) begin
         next_r.in_full_flag = 1'b0; // [RULE14]
         next_r.out_full_flag = 1'b0; // [RULE14]
         next_r.cyc = psp_pkg::PSP_IDLE;
      end

      // ======================================================
      // pin drive
      if (r.slave_mode_sel) begin
         // strobe pins stay inputs whatever the direction bits say
         next_r.dout = r.out_latch;
         next_r.doe = {8{rd_act}}; // [RULE6] [RULE11]
         next_r.soe = 3'h0; // [RULE4]
      end else begin
         next_r.dout = r.out_latch;
         next_r.doe = ~r.data_pin_dir;
         next_r.soe = ~r.strobe_pin_dir; // [RULE17]
      end
      next_r.sout = 3'h0;
      next_r.irq = |(next_r.flag_reg & next_r.mask_reg); // [RULE16]
   end

   // =========================================================
   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.arready <= 1'b1;
         r.data_pin_dir <= psp_pkg::DDIR_RESET;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.strobe_pin_dir <= psp_pkg::DIR_RESET; // [RULE17]
      end else begin
         r <= next_r;
      end
   end

   // =========================================================
   // outputs, each straight from a flop
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign data_pin_o = r.dout;
   assign data_pin_oe = r.doe;
   assign strobe_pin_o = r.sout;
   assign strobe_pin_oe = r.soe;
   assign irq = r.irq;
endmodule : psp_top

// ===== test/psp_host_bfm.sv
// psp_host_bfm: external microprocessor on the slave port
`timescale 1ns/1ps
// ==========================================================
// host bus master
module psp_host_bfm (
   input wire logic aclk,
   input wire logic [7:0] dq_i,
   output logic [2:0] strobe_n,
   output logic [7:0] dq_o
);
   initial begin
      strobe_n = 3'h7;
      dq_o = 8'h00;
   end
   // s: cs_n, wr_n, rd_n; 14 idle cycles cover completion
   task automatic cyc(input logic [2:0] s, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge aclk);
      strobe_n <= s;
      dq_o <= d;
      repeat (6) @(posedge aclk);
      q = dq_i;
      strobe_n <= 3'h7;
      dq_o <= ~d; // released bus must not keep the old value
      repeat (14) @(posedge aclk);
   endtask : cyc
endmodule : psp_host_bfm

// ===== test/psp_top_sva.sv
// psp_top_sva: port-level checks for the slave port
`timescale 1ns/1ps
// ==========================================================
// checker
module psp_top_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [7:0] data_pin_oe,
   input wire logic [2:0] strobe_pin_i,
   input wire logic [2:0] strobe_pin_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_aw_blocked: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("slot open early");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_b_single: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write answer repeated");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   a_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   // sync delay is about three cycles, so five is safe
   a_oe_idle: assert property (
      (strobe_pin_i[0] || strobe_pin_i[2]) [*5] |->
      data_pin_oe == 8'h00) else $error("pins driven without read");
   a_oe_whole: assert property (
      data_pin_oe == 8'h00 || data_pin_oe == 8'hFF)
      else $error("data pins partly driven");
   a_dir_write: assert property ($changed(strobe_pin_oe) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("strobe enable moved alone");
endmodule : psp_top_sva

bind psp_top psp_top_sva chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rdata, .data_pin_oe, .strobe_pin_i, .strobe_pin_oe);

// ===== test/tb_parallel_slave_port.sv
// tb_parallel_slave_port: self-checking bench with a reference model
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb_parallel_slave_port;
   logic aclk, aresetn, irq;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, bres;
   logic [7:0] data_pin_i, data_pin_o, data_pin_oe, host_dq, b, q;
   logic [2:0] strobe_pin_i, strobe_pin_o, strobe_pin_oe, host_sb, dir;
   logic in_full, out_full, ovr, mode, pflag, msk;
   logic [7:0] inq[$];
   int miscompares, n_tests;
   assign data_pin_i = (data_pin_o & data_pin_oe) | (host_dq & ~data_pin_oe);
   assign strobe_pin_i = (strobe_pin_o & strobe_pin_oe) |
      (host_sb & ~strobe_pin_oe);
   psp_top dut (.*);
   psp_host_bfm host (.aclk(aclk), .dq_i(data_pin_i), .strobe_n(host_sb),
      .dq_o(host_dq));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      bres = s_axi_bresp;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [9:0] e);
      @(posedge aclk);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk({s_axi_rresp, s_axi_rdata}, {e[9:8], 24'h000000, e[7:0]});
   endtask : rc
   task automatic st();
      rc(psp_pkg::IDX_STAT, {2'h0, in_full, out_full, ovr, mode, 1'b0, dir});
      rc(psp_pkg::IDX_FLAG, {2'h0, pflag, 7'h00});
      chk({33'h0, irq}, {33'h0, pflag & msk});
   endtask : st
   task automatic setst(input logic [7:0] v);
      wr(psp_pkg::IDX_STAT, v);
      mode = v[4];
      dir = v[2:0];
      ovr = ovr & v[5];
      in_full = in_full & mode;
      out_full = out_full & mode;
   endtask : setst
   task automatic hwr();
      b = rnd();
      ovr = ovr | (in_full & mode);
      in_full = mode;
      pflag = pflag | mode;
      if (mode) inq.push_back(b);
      host.cyc(3'h1, b, q);
   endtask : hwr
   task automatic frd();
      rc(psp_pkg::IDX_DATA, {2'h0, inq[$]});
      inq.delete();
      in_full = 1'b0;
   endtask : frd
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      end_of_test();
   end
   initial begin
      seed = 32'hEE72E2BA;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
      {in_full, out_full, ovr, mode, pflag, msk} = 6'h00;
      dir = 3'h7;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      st();
      rc(psp_pkg::IDX_MASK, 10'h000);
      rc(8'h40, {psp_pkg::RESP_SLVERR, 8'h00});
      wr(8'h40, 8'hFF);
      chk({32'h0, bres}, {32'h0, psp_pkg::RESP_SLVERR});
      wr(psp_pkg::IDX_ANLG, 8'h07);
      setst(8'hFF);
      wr(psp_pkg::IDX_MASK, 8'h80);
      msk = 1'b1;
      st();
      $display("test reset_and_setup done");
      hwr();
      st();
      frd();
      st();
      wr(psp_pkg::IDX_FLAG, 8'h80);
      pflag = 1'b0;
      st();
      $display("test host_write done");
      hwr();
      hwr();
      st();
      setst(8'h3F);
      st();
      frd();
      host.cyc(3'h5, rnd(), q);
      st();
      $display("test overrun_and_select done");
      b = rnd();
      wr(psp_pkg::IDX_DATA, b);
      out_full = 1'b1;
      st();
      host.cyc(3'h2, rnd(), q);
      chk({26'h0, q}, {26'h0, b});
      out_full = 1'b0;
      pflag = 1'b1;
      st();
      wr(psp_pkg::IDX_MASK, 8'h00);
      msk = 1'b0;
      st();
      $display("test host_read done");
      wr(psp_pkg::IDX_DATA, rnd());
      out_full = 1'b1;
      hwr();
      setst(8'h27);
      st();
      setst(8'h00);
      st();
      chk({31'h0, strobe_pin_oe}, {31'h0, 3'h7});
      setst(8'h07);
      st();
      $display("test mode_off done");
      end_of_test();
   end
endmodule : tb_parallel_slave_port
